/* File: verilog/ctr_regs.sv */
`timescale 1ns/10ps

module ctr_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire ctr_pkg::ctr_req_t req,
  input  wire logic             supply_input_ok,
  output      logic [7:0]       rdata_q,
  output      logic             rvalid_q,
  output      ctr_pkg::ctr_thr_t thr_q,
  output      ctr_pkg::ctr_tmr_t tmr_q,
  output      ctr_pkg::ctr_fn_t  fn_q
);
  import ctr_pkg::*;

  // the address field is eight bits wide on the control bus
  if (ADDR_W != 8) begin : g_bad_addr_w
    $error("ctr_regs: ADDR_W must be 8");
  end

  // address match, used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // recharge threshold table
  function automatic logic [11:0] rch_mv(input logic [1:0] c);
    case (c)
      2'h0:    rch_mv = RCH_MV0;
      2'h1:    rch_mv = RCH_MV1;
      2'h2:    rch_mv = RCH_MV2;
      default: rch_mv = RCH_MV3;
    endcase
  endfunction : rch_mv

  // dead-battery threshold table
  function automatic logic [11:0] dead_mv(input logic [1:0] c);
    case (c)
      2'h0:    dead_mv = DEAD_MV0;
      2'h1:    dead_mv = DEAD_MV1;
      2'h2:    dead_mv = DEAD_MV2;
      default: dead_mv = DEAD_MV3;
    endcase
  endfunction : dead_mv

  // weak threshold rises one step per code
  function automatic logic [11:0] weak_mv(input logic [2:0] c);
    logic [11:0] s;
    s = WEAK_MV_STEP * {9'h000, c};
    weak_mv = WEAK_MV_BASE + s;
  endfunction : weak_mv

  logic [7:0] vth_q;
  logic [7:0] vth_d;
  logic [7:0] tmr_reg_q;
  logic [7:0] tmr_reg_d;
  logic [7:0] fn1_q;
  logic [7:0] fn1_d;
  logic       wd_restart_d;
  logic [7:0] rdata_d;

  // next register values; masked bits never store
  always_comb begin
    vth_d        = vth_q;
    tmr_reg_d    = tmr_reg_q;
    fn1_d        = fn1_q;
    wd_restart_d = 1'b0;
    if (req.wr && hit(req.addr, ADDR_VTH)) begin
      vth_d = req.wdata & MASK_VTH;
    end else if (req.wr && hit(req.addr, ADDR_TMR)) begin
      tmr_reg_d    = req.wdata & MASK_TMR;
      wd_restart_d = req.wdata[B_WD_RST];
    end else if (req.wr && hit(req.addr, ADDR_FN1)) begin
      fn1_d = req.wdata & MASK_FN1;
    end
  end

  // register storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      vth_q     <= RST_VTH;
      tmr_reg_q <= RST_TMR;
      fn1_q     <= RST_FN1;
    end else begin
      vth_q     <= vth_d;
      tmr_reg_q <= tmr_reg_d;
      fn1_q     <= fn1_d;
    end
  end

  // read mux; unmapped offsets return zero
  always_comb begin
    rdata_d = 8'h00;
    if (hit(req.addr, ADDR_VTH)) begin
      rdata_d = vth_q;
    end else if (hit(req.addr, ADDR_TMR)) begin
      rdata_d = tmr_reg_q;
    end else if (hit(req.addr, ADDR_FN1)) begin
      rdata_d = fn1_q;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // decoded thresholds, following the stored fields
  always_ff @(posedge mclk) begin
    if (rst) begin
      thr_q.recharge_disable <= RST_VTH[B_RCH_DIS];
      thr_q.recharge_mv      <= rch_mv(RST_VTH[B_RCH_LO +: 2]);
      thr_q.dead_battery_mv  <= dead_mv(RST_VTH[B_DEAD_LO +: 2]);
      thr_q.low_battery_mv   <= weak_mv(RST_VTH[B_WEAK_LO +: 3]);
    end else begin
      thr_q.recharge_disable <= vth_d[B_RCH_DIS];
      thr_q.recharge_mv      <= rch_mv(vth_d[B_RCH_LO +: 2]);
      thr_q.dead_battery_mv  <= dead_mv(vth_d[B_DEAD_LO +: 2]);
      thr_q.low_battery_mv   <= weak_mv(vth_d[B_WEAK_LO +: 3]);
    end
  end

  // timer enables and periods
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr_q.charge_complete_timer_en <= RST_TMR[B_CHARGE_COMPLETE_TIME_EN];
      tmr_q.deglitch_ms              <= DEGLITCH_MS;
      tmr_q.trickle_fast_timer_en    <= RST_TMR[B_CHGT_EN];
      tmr_q.trickle_s                <= TRK_S_LONG;
      tmr_q.fast_min                 <= FAST_MIN_LONG;
      tmr_q.safety_watchdog_en       <= RST_TMR[B_WD_EN];
      tmr_q.watchdog_s               <= WD_S_SHORT;
      tmr_q.safety_min               <= SAFETY_MIN;
      tmr_q.safety_watchdog_restart  <= 1'b0;
    end else begin
      // deglitch stays on whatever the enable says
      tmr_q.charge_complete_timer_en <= tmr_reg_d[B_CHARGE_COMPLETE_TIME_EN];
      tmr_q.deglitch_ms              <= DEGLITCH_MS;
      tmr_q.trickle_fast_timer_en    <= tmr_reg_d[B_CHGT_EN];
      tmr_q.trickle_s  <= tmr_reg_d[B_CHGT_LP] ? TRK_S_LONG
                                               : TRK_S_SHORT;
      tmr_q.fast_min   <= tmr_reg_d[B_CHGT_LP] ? FAST_MIN_LONG
                                               : FAST_MIN_SHRT;
      tmr_q.safety_watchdog_en <= tmr_reg_d[B_WD_EN];
      tmr_q.watchdog_s <= tmr_reg_d[B_WD_LP] ? WD_S_LONG
                                             : WD_S_SHORT;
      tmr_q.safety_min <= SAFETY_MIN;
      tmr_q.safety_watchdog_restart <= wd_restart_d;
    end
  end

  // functional controls; device disable overrides the charger
  always_ff @(posedge mclk) begin
    if (rst) begin
      fn_q <= '0;
    end else begin
      fn_q.charger_on <= ~fn1_d[B_DEV_DIS];
      fn_q.battery_monitor_on <= supply_input_ok
                                 | fn1_d[B_BMON_F];
      fn_q.thermistor_source_on <= supply_input_ok
                                   | fn1_d[B_THR_F];
      fn_q.regulator_on <= ~fn1_d[B_LDO_OFF]
                           & ~fn1_d[B_DEV_DIS];
      fn_q.iso_switch_on <= fn1_d[B_LDO_OFF]
                            & ~fn1_d[B_CHG_EN];
      fn_q.end_of_charge_allowed <= fn1_d[B_EOC_EN];
      fn_q.charging_on <= fn1_d[B_CHG_EN]
                          & ~fn1_d[B_DEV_DIS];
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_recharge_dis_wr: assert property (
    req.wr && req.addr == ADDR_VTH
    |=> thr_q.recharge_disable == $past(req.wdata[7]))
    else $error("recharge disable not taken from write");

  a_recharge_mv_map: assert property (
    thr_q.recharge_mv == 12'h050 + 12'h03C * {10'h000, vth_q[6:5]})
    else $error("recharge threshold mismatch");

  a_dead_mv_map: assert property (
    thr_q.dead_battery_mv == (vth_q[4:3] == 2'h0 ? 12'h7D0 :
                              vth_q[4:3] == 2'h1 ? 12'h9C4 :
                              vth_q[4:3] == 2'h2 ? 12'hA28 : 12'hB54))
    else $error("dead battery threshold mismatch");

  a_weak_mv_map: assert property (
    thr_q.low_battery_mv == 12'hA8C + 12'h064 * {9'h000, vth_q[2:0]})
    else $error("weak threshold mismatch");

  a_deglitch_keep: assert property (
    !tmr_q.charge_complete_timer_en |-> tmr_q.deglitch_ms == 10'h01F)
    else $error("deglitch period lost");

  a_chg_timer_off: assert property (
    req.wr && req.addr == ADDR_TMR && !req.wdata[4]
    |=> !tmr_q.trickle_fast_timer_en ##1
        (!tmr_q.trickle_fast_timer_en ||
         $past(req.wr && req.addr == ADDR_TMR)))
    else $error("charge timers not disabled");

  a_chg_period: assert property (
    tmr_q.trickle_s == (tmr_reg_q[3] ? 10'h03C : 10'h01E) &&
    tmr_q.fast_min == (tmr_reg_q[3] ? 10'h258 : 10'h12C))
    else $error("charge timer period mismatch");

  a_wd_enable: assert property (
    tmr_q.safety_watchdog_en == tmr_reg_q[2])
    else $error("watchdog enable mismatch");

  a_safety_watchdog_long_period: assert property (
    tmr_q.watchdog_s == (tmr_reg_q[1] ? 10'h040 : 10'h020) &&
    tmr_q.safety_min == 10'h028)
    else $error("watchdog period mismatch");

  a_wd_restart: assert property (
    req.wr && req.addr == ADDR_TMR && req.wdata[0]
    |=> tmr_q.safety_watchdog_restart ##1
        (!tmr_q.safety_watchdog_restart ||
         $past(req.wr && req.addr == ADDR_TMR && req.wdata[0])))
    else $error("watchdog restart pulse wrong");

  a_dev_disable: assert property (
    fn1_q[6] |-> !fn_q.charger_on && !fn_q.charging_on)
    else $error("charger on while disabled");

  a_monitor_on: assert property (
    !$past(rst) && $past(supply_input_ok) |-> fn_q.battery_monitor_on)
    else $error("battery monitor off with valid supply");

  a_therm_on: assert property (
    !$past(rst) |->
    fn_q.thermistor_source_on == ($past(supply_input_ok) || fn1_q[4]))
    else $error("thermistor source mismatch");

  a_iso_steer: assert property (
    fn1_q[3] |-> !fn_q.regulator_on &&
                 fn_q.iso_switch_on == !fn1_q[0])
    else $error("isolation switch steering wrong");

  a_eoc_allow: assert property (
    !$past(rst) |-> fn_q.end_of_charge_allowed == fn1_q[2])
    else $error("end of charge permission mismatch");

  a_chg_enable: assert property (
    req.wr && req.addr == ADDR_FN1 && req.wdata[0] && !req.wdata[6]
    |=> fn_q.charging_on)
    else $error("charging not enabled by write");

  a_rd_zero_bits: assert property (
    rvalid_q && $past(req.addr) == ADDR_TMR |-> rdata_q[7:6] == 2'h0
    && rdata_q[0] == 1'b0)
    else $error("unused timer bits read nonzero");

  a_reset_vals: assert property (
    $past(rst) |-> vth_q == 8'h63 && tmr_reg_q == 8'h38 &&
    fn1_q == 8'h04)
    else $error("reset values wrong");

  // read port timing, register storage and decoded outputs
  a_rvalid_pulse: assert property (
    !$past(rst) |-> rvalid_q == $past(req.rd))
    else $error("read answer strobe wrong");

  a_rdata_hold: assert property (
    !$past(rst) && !$past(req.rd) |-> $stable(rdata_q))
    else $error("read data changed without a read");

  a_unmapped_rd: assert property (
    req.rd && req.addr != ADDR_VTH && req.addr != ADDR_TMR &&
    req.addr != ADDR_FN1 |=> rdata_q == 8'h00)
    else $error("unmapped read nonzero");

  a_fn_rd_zero: assert property (
    rvalid_q && $past(req.addr) == ADDR_FN1 |->
    rdata_q[7] == 1'b0 && rdata_q[1] == 1'b0)
    else $error("unused functional bits read nonzero");

  a_vth_wr_land: assert property (
    req.wr && req.addr == ADDR_VTH |=> vth_q == $past(req.wdata))
    else $error("threshold write not stored");

  a_tmr_wr_land: assert property (
    req.wr && req.addr == ADDR_TMR
    |=> tmr_reg_q == ($past(req.wdata) & 8'h3E))
    else $error("timer write not stored as masked");

  a_fn1_wr_land: assert property (
    req.wr && req.addr == ADDR_FN1
    |=> fn1_q == ($past(req.wdata) & 8'h7D))
    else $error("functional write not stored as masked");

  a_hold_vals: assert property (
    !$past(rst) && !$past(req.wr) |->
    $stable(vth_q) && $stable(tmr_reg_q) && $stable(fn1_q))
    else $error("register changed without a write");

  a_unmapped_wr: assert property (
    req.wr && req.addr != ADDR_VTH && req.addr != ADDR_TMR &&
    req.addr != ADDR_FN1
    |=> $stable(vth_q) && $stable(tmr_reg_q) && $stable(fn1_q))
    else $error("unmapped write changed a register");

  a_restart_src: assert property (
    tmr_q.safety_watchdog_restart |->
    $past(req.wr && req.addr == ADDR_TMR && req.wdata[0]))
    else $error("restart pulse without a restart write");

  a_chg_timer_on: assert property (
    req.wr && req.addr == ADDR_TMR && req.wdata[4]
    |=> tmr_q.trickle_fast_timer_en)
    else $error("charge timers not enabled");

  a_charge_complete_time_enable: assert property (
    tmr_q.charge_complete_timer_en == tmr_reg_q[5])
    else $error("charge complete timer enable mismatch");

  a_charger_on: assert property (
    !$past(rst) |-> fn_q.charger_on == !fn1_q[6])
    else $error("charger on state mismatch");

  a_regulator_on: assert property (
    !$past(rst) |-> fn_q.regulator_on == !(fn1_q[3] || fn1_q[6]))
    else $error("regulator state mismatch");

endmodule : ctr_regs

/* File: verilog/ctr_pkg.sv */
package ctr_pkg;

  // register offsets on the control bus
  localparam logic [7:0] ADDR_VTH = 8'h05;
  localparam logic [7:0] ADDR_TMR = 8'h06;
  localparam logic [7:0] ADDR_FN1 = 8'h07;

  // reset values
  localparam logic [7:0] RST_VTH = 8'h63;
  localparam logic [7:0] RST_TMR = 8'h38;
  localparam logic [7:0] RST_FN1 = 8'h04;

  // writable bit masks; other bits read as zero
  localparam logic [7:0] MASK_VTH = 8'hFF;
  localparam logic [7:0] MASK_TMR = 8'h3E;
  localparam logic [7:0] MASK_FN1 = 8'h7D;

  // threshold register fields
  localparam int B_RCH_DIS = 7;
  localparam int B_RCH_LO  = 5;
  localparam int B_DEAD_LO = 3;
  localparam int B_WEAK_LO = 0;

  // timer register fields
  localparam int B_CHARGE_COMPLETE_TIME_EN = 5;
  localparam int B_CHGT_EN = 4;
  localparam int B_CHGT_LP = 3;
  localparam int B_WD_EN   = 2;
  localparam int B_WD_LP   = 1;
  localparam int B_WD_RST  = 0;

  // functional register fields
  localparam int B_DEV_DIS = 6;
  localparam int B_BMON_F  = 5;
  localparam int B_THR_F   = 4;
  localparam int B_LDO_OFF = 3;
  localparam int B_EOC_EN  = 2;
  localparam int B_CHG_EN  = 0;

  // threshold tables in millivolts
  localparam logic [11:0] RCH_MV0  = 12'h050;
  localparam logic [11:0] RCH_MV1  = 12'h08C;
  localparam logic [11:0] RCH_MV2  = 12'h0C8;
  localparam logic [11:0] RCH_MV3  = 12'h104;
  localparam logic [11:0] DEAD_MV0 = 12'h7D0;
  localparam logic [11:0] DEAD_MV1 = 12'h9C4;
  localparam logic [11:0] DEAD_MV2 = 12'hA28;
  localparam logic [11:0] DEAD_MV3 = 12'hB54;
  localparam logic [11:0] WEAK_MV_BASE = 12'hA8C;
  localparam logic [11:0] WEAK_MV_STEP = 12'h064;

  // timer periods in their own units
  localparam logic [9:0] TRK_S_SHORT   = 10'h01E;
  localparam logic [9:0] TRK_S_LONG    = 10'h03C;
  localparam logic [9:0] FAST_MIN_SHRT = 10'h12C;
  localparam logic [9:0] FAST_MIN_LONG = 10'h258;
  localparam logic [9:0] WD_S_SHORT    = 10'h020;
  localparam logic [9:0] WD_S_LONG     = 10'h040;
  localparam logic [9:0] SAFETY_MIN    = 10'h028;
  localparam logic [9:0] DEGLITCH_MS   = 10'h01F;

  // register access request as decoded by the serial bus slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctr_req_t;

  // decoded thresholds
  typedef struct packed {
    logic        recharge_disable;
    logic [11:0] recharge_mv;
    logic [11:0] dead_battery_mv;
    logic [11:0] low_battery_mv;
  } ctr_thr_t;

  // timer settings
  typedef struct packed {
    logic       charge_complete_timer_en;
    logic [9:0] deglitch_ms;
    logic       trickle_fast_timer_en;
    logic [9:0] trickle_s;
    logic [9:0] fast_min;
    logic       safety_watchdog_en;
    logic [9:0] watchdog_s;
    logic [9:0] safety_min;
    logic       safety_watchdog_restart;
  } ctr_tmr_t;

  // functional controls to the analog side
  typedef struct packed {
    logic charger_on;
    logic battery_monitor_on;
    logic thermistor_source_on;
    logic regulator_on;
    logic iso_switch_on;
    logic end_of_charge_allowed;
    logic charging_on;
  } ctr_fn_t;

endpackage : ctr_pkg

/* File: verification/ctr_regs_tb_top.sv */
`timescale 1ns/10ps

// compare one value, count it, report a difference at once
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); \
    n_mismatch++; \
  end \
end

module ctr_regs_tb_top;
  import ctr_pkg::*;

  logic        mclk;
  logic        rst;
  ctr_req_t    req;
  logic        supply_input_ok;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  ctr_thr_t    thr_q;
  ctr_tmr_t    tmr_q;
  ctr_fn_t     fn_q;
  ctr_fn_t     fn_exp;
  logic [7:0]  d;
  logic [11:0] rch_tab [4];
  logic [11:0] dead_tab [4];
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cycle_cnt   = 0;

  ctr_regs #(.ADDR_W(8)) uut (
    .mclk            (mclk),
    .rst             (rst),
    .req             (req),
    .supply_input_ok (supply_input_ok),
    .rdata_q         (rdata_q),
    .rvalid_q        (rvalid_q),
    .thr_q           (thr_q),
    .tmr_q           (tmr_q),
    .fn_q            (fn_q)
  );

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // verdict and end of run
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // cut a hang short; the tests need about 1400 cycles
  always @(posedge mclk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // one register write, strobe held for exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge mclk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= dat;
    @(posedge mclk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // one register read; answer stands for the cycle after the taking edge
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, rvalid_q)
    `CHK("read data", e, rdata_q)
  endtask : chk_rd

  // timer outputs from the five writable timer bits
  task automatic chk_tmr(input logic [4:0] f);
    ctr_tmr_t e;
    e.charge_complete_timer_en = f[4];
    e.deglitch_ms              = 10'h01F;
    e.trickle_fast_timer_en    = f[3];
    e.trickle_s                = f[2] ? 10'h03C : 10'h01E;
    e.fast_min                 = f[2] ? 10'h258 : 10'h12C;
    e.safety_watchdog_en       = f[1];
    e.watchdog_s               = f[0] ? 10'h040 : 10'h020;
    e.safety_min               = 10'h028;
    e.safety_watchdog_restart  = 1'b0;
    `CHK("timer outputs", e, tmr_q)
  endtask : chk_tmr

  // threshold outputs and read-back after reset
  task automatic chk_reset_vals();
    `CHK("recharge off", 1'b0, thr_q.recharge_disable)
    `CHK("recharge mv", 12'h104, thr_q.recharge_mv)
    `CHK("dead mv", 12'h7D0, thr_q.dead_battery_mv)
    `CHK("weak mv", 12'hBB8, thr_q.low_battery_mv)
    chk_tmr(5'h1C);
    chk_rd(ADDR_VTH, 8'h63);
    chk_rd(ADDR_TMR, 8'h38);
    chk_rd(ADDR_FN1, 8'h04);
  endtask : chk_reset_vals

  // main sequence
  initial begin
    rst             = 1'b1;
    req             = '0;
    supply_input_ok = 1'b0;
    d               = 8'h00;
    rch_tab  = '{12'h050, 12'h08C, 12'h0C8, 12'h104};
    dead_tab = '{12'h7D0, 12'h9C4, 12'hA28, 12'hB54};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk_reset_vals();
    @(posedge mclk);
    #1;
    `CHK("read valid end", 1'b0, rvalid_q)
    `CHK("read hold", 8'h04, rdata_q)

    // every threshold code and the recharge disable
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[1:0], i[1:0], i[2:0]};
      wr(ADDR_VTH, d);
      `CHK("recharge off", i[0], thr_q.recharge_disable)
      `CHK("recharge mv", rch_tab[i[1:0]], thr_q.recharge_mv)
      `CHK("dead mv", dead_tab[i[1:0]], thr_q.dead_battery_mv)
      `CHK("weak mv", 12'hA8C + 12'h064 * i[2:0], thr_q.low_battery_mv)
      chk_rd(ADDR_VTH, d);
    end

    // restart bit pulses once and reads back zero with unused bits
    wr(ADDR_TMR, 8'hFF);
    `CHK("restart pulse", 1'b1, tmr_q.safety_watchdog_restart)
    @(posedge mclk);
    #1;
    `CHK("restart end", 1'b0, tmr_q.safety_watchdog_restart)
    chk_rd(ADDR_TMR, 8'h3E);

    // every combination of timer enables and periods
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_TMR, {2'b00, i[4:0], 1'b0});
      `CHK("no restart", 1'b0, tmr_q.safety_watchdog_restart)
      chk_tmr(i[4:0]);
    end

    // every functional value, supply state riding on the unused bit
    for (int k = 0; k < 256; k++) begin
      d = k[7:0];
      @(posedge mclk);
      supply_input_ok <= d[7];
      wr(ADDR_FN1, d);
      fn_exp.charger_on            = !d[6];
      fn_exp.battery_monitor_on    = d[7] | d[5];
      fn_exp.thermistor_source_on  = d[7] | d[4];
      fn_exp.regulator_on          = !d[3] && !d[6];
      fn_exp.iso_switch_on         = d[3] && !d[0];
      fn_exp.end_of_charge_allowed = d[2];
      fn_exp.charging_on           = d[0] && !d[6];
      `CHK("fn outputs", fn_exp, fn_q)
      chk_rd(ADDR_FN1, d & 8'h7D);
    end

    // unmapped places ignore writes and read zero
    wr(8'h08, 8'hFF);
    chk_rd(8'h08, 8'h00);
    chk_rd(8'h04, 8'h00);
    chk_rd(ADDR_VTH, 8'hFF);

    // reset in mid-run restores every field
    wr(ADDR_TMR, 8'h06);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk_reset_vals();
    end_sim();
  end

endmodule : ctr_regs_tb_top
